//--- esdc_pkg.sv
// Purpose: Shared constants for the serial-mode drive control block
// Assumes: 10 MHz system clock
// Notes: Opcodes sit in command bits 15..12, modifiers in bits 11..8
package esdc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int SEL_NS = 1000;
  localparam int SEL_CYC = (SEL_NS * (CLK_HZ / 1_000_000)) / 1000 < 1 ? 1 :
    (SEL_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int ACK_NS = 2000;
  localparam int ACK_CYC = (ACK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int HEAD_W = 4;
  localparam int UNIT_W = 3;
  localparam int CMD_W = 16;
  localparam int OP_HI = 15;
  localparam int OP_LO = 12;
  localparam int MOD_HI = 11;
  localparam int MOD_LO = 8;
  localparam logic [3:0] OP_SEEK = 4'h0;
  localparam logic [3:0] OP_RECAL = 4'h1;
  localparam logic [3:0] OP_STATUS = 4'h2;
  localparam logic [3:0] OP_CONFIG = 4'h3;
  localparam logic [3:0] OP_HEAD_GROUP = 4'h4;
  localparam logic [3:0] OP_CONTROL = 4'h5;
  localparam logic [3:0] OP_STROBE_OFS = 4'h6;
  localparam logic [3:0] OP_TRACK_OFS = 4'h7;
  localparam logic [3:0] OP_DIAG = 4'h8;
  localparam logic [3:0] OP_SET_BPS = 4'h9;
  localparam logic [3:0] OP_SET_CONFIG = 4'he;
  localparam logic [3:0] MOD_RESET_ATTN = 4'h0;
  localparam logic [3:0] MOD_START_MOTOR = 4'h3;
  localparam int ST_INVALID_BIT = 0;
  localparam logic [1:0] OFS_NONE = 2'h0;
  localparam logic [1:0] STROBE_SINGLE = 2'h1;
  typedef enum {XS_IDLE, XS_WAIT} esdc_xfer_t;
endpackage : esdc_pkg

//--- esdc_cmd_decode.sv
// Purpose: Combinational opcode and modifier decode of a command word
// Assumes: Word fully assembled before strobe
// Notes: Pure logic, no state
`timescale 1ns/1ps
module esdc_cmd_decode
  import esdc_pkg::*;
(
  input wire logic [CMD_W-1:0] cmd_in,
  output logic valid_out,
  output logic clr_attn_out,
  output logic start_motor_out,
  output logic strobe_ofs_out,
  output logic track_ofs_out
);
  logic [3:0] op;
  logic [3:0] modf;
  assign op = cmd_in[OP_HI:OP_LO];
  assign modf = cmd_in[MOD_HI:MOD_LO];
  always_comb begin
    valid_out = 1'b1;
    clr_attn_out = 1'b0;
    start_motor_out = 1'b0;
    strobe_ofs_out = 1'b0;
    track_ofs_out = 1'b0;
    case (op)
      OP_SEEK, OP_RECAL, OP_STATUS, OP_CONFIG, OP_DIAG, OP_SET_BPS, OP_SET_CONFIG: begin
        valid_out = 1'b1;
      end
      OP_CONTROL: begin
        if (modf == MOD_RESET_ATTN) begin
          clr_attn_out = 1'b1;
        end else if (modf == MOD_START_MOTOR) begin
          start_motor_out = 1'b1;
        end else begin
          valid_out = 1'b0;
        end
      end
      OP_STROBE_OFS: begin
        strobe_ofs_out = 1'b1;
      end
      OP_TRACK_OFS: begin
        track_ofs_out = 1'b1;
      end
      default: begin
        valid_out = 1'b0;
      end
    endcase
  end
endmodule : esdc_cmd_decode

//--- esdc_drive_ctrl.sv
// Purpose: Drive-side select, head select and serial command logic
// Assumes: All inputs except RST_N_IN synchronous to SYS_CLK_IN; levels already resolved from line pairs
// Notes: Command bits shift in MSB first, one bit per request edge
// How it works
// - Ready output valid within one microsecond of selection.
// - Own unit address on select lines asserts selected within one microsecond.
// - Other unit address deselects within one microsecond.
// - Select lines compared to a jumpered unit address, seven units.
// - Read data valid within one clock (100 ns) of a head change.
// - Ready and command complete do not change on head change.
// - Four head-select lines choose the data head.
// - Each request edge gets a matching acknowledge edge, about 2 us later.
// - Opcode is command bits fifteen to twelve.
// - Unimplemented commands are invalid.
// - Reset attention/status and start motor control commands implemented.
// - Three strobe offset levels map to one physical offset.
// - Three track offset levels each get a distinct offset.
// - Serial command mode only, no step mode.
// - Differential plus above minus means asserted.
// - Invalid command raises attention and the invalid-command status bit.
// - Control modifier 0000 clears attention, 0011 starts spindle.
`timescale 1ns/1ps
module esdc_drive_ctrl
  import esdc_pkg::*;
#(
  parameter int ACK_DELAY = ACK_CYC
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [UNIT_W-1:0] UNIT_ADDR_IN,
  input wire logic [UNIT_W-1:0] DRIVE_SEL_IN,
  input wire logic [HEAD_W-1:0] HEAD_SEL_IN,
  input wire logic WRITE_GATE_IN,
  input wire logic READ_GATE_IN,
  input wire logic XFER_REQ_IN,
  input wire logic CMD_BIT_IN,
  input wire logic MECH_READY_IN,
  input wire logic MECH_DONE_IN,
  output logic SELECTED_OUT,
  output logic READY_OUT,
  output logic CMD_DONE_OUT,
  output logic ATTN_OUT,
  output logic XFER_ACK_OUT,
  output logic [HEAD_W-1:0] HEAD_OUT,
  output logic WRITE_EN_OUT,
  output logic READ_EN_OUT,
  output logic [CMD_W-1:0] CMD_WORD_OUT,
  output logic CMD_STB_OUT,
  output logic [11:0] STATUS_OUT,
  output logic MOTOR_ON_OUT,
  output logic [1:0] STROBE_OFS_OUT,
  output logic [1:0] TRACK_OFS_OUT
);
  // Counter is 16 bits wide and needs at least one wait cycle
  if (ACK_DELAY < 1 || ACK_DELAY > 65535) begin : g_bad_delay
    $error("ACK_DELAY out of range");
  end

  // Two-flop release of the asynchronous reset
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Selection and head path; inputs are resolved levels, high is asserted
  logic sel_q, sel_d;
  logic [HEAD_W-1:0] head_q, head_d;
  always_comb begin
    sel_d = (DRIVE_SEL_IN == UNIT_ADDR_IN) && (DRIVE_SEL_IN != '0);
    head_d = HEAD_SEL_IN;
  end

  // Command transfer state
  esdc_xfer_t xs_q, xs_d;
  logic req_q, req_d;
  logic ack_q, ack_d;
  logic [15:0] cnt_q, cnt_d;
  logic [CMD_W-1:0] sh_q, sh_d;
  logic [4:0] nbit_q, nbit_d;
  logic [CMD_W-1:0] word_q, word_d;
  logic stb_q, stb_d;
  logic done_q, done_d;
  logic attn_q, attn_d;
  logic [11:0] st_q, st_d;
  logic motor_q, motor_d;
  logic [1:0] sofs_q, sofs_d;
  logic [1:0] tofs_q, tofs_d;
  logic dec_valid, dec_clr, dec_start, dec_sofs, dec_tofs;
  logic [CMD_W-1:0] next_word;

  // Serial command path only, no step pulses
  assign next_word = {sh_q[CMD_W-2:0], CMD_BIT_IN};

  esdc_cmd_decode u_dec (
    .cmd_in(next_word),
    .valid_out(dec_valid),
    .clr_attn_out(dec_clr),
    .start_motor_out(dec_start),
    .strobe_ofs_out(dec_sofs),
    .track_ofs_out(dec_tofs)
  );

  always_comb begin
    xs_d = xs_q;
    req_d = req_q;
    ack_d = ack_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    nbit_d = nbit_q;
    word_d = word_q;
    stb_d = 1'b0;
    done_d = done_q;
    attn_d = attn_q;
    st_d = st_q;
    motor_d = motor_q;
    sofs_d = sofs_q;
    tofs_d = tofs_q;
    case (xs_q)
      XS_IDLE: begin
        if (sel_q && XFER_REQ_IN != req_q) begin
          req_d = XFER_REQ_IN;
          cnt_d = 16'(ACK_DELAY - 1);
          xs_d = XS_WAIT;
          if (nbit_q == 5'h0) begin
            done_d = 1'b0;
          end
        end
      end
      XS_WAIT: begin
        if (cnt_q != 16'h0) begin
          cnt_d = cnt_q - 16'h1;
        end else begin
          ack_d = req_q;
          xs_d = XS_IDLE;
          sh_d = next_word;
          if (nbit_q == 5'(CMD_W - 1)) begin
            nbit_d = 5'h0;
            word_d = next_word;
            stb_d = 1'b1;
            done_d = 1'b1;
            if (!dec_valid) begin
              attn_d = 1'b1;
              st_d[ST_INVALID_BIT] = 1'b1;
            end else if (dec_clr) begin
              attn_d = 1'b0;
              st_d = '0;
            end else if (dec_start) begin
              motor_d = 1'b1;
            end else if (dec_sofs) begin
              sofs_d = (next_word[MOD_HI:MOD_LO] == 4'h0) ? OFS_NONE : STROBE_SINGLE;
            end else if (dec_tofs) begin
              tofs_d = next_word[MOD_LO+1:MOD_LO];
            end
          end else begin
            nbit_d = nbit_q + 5'h1;
          end
        end
      end
      default: xs_d = XS_IDLE;
    endcase
    // Mechanics event wins over a clear in the same cycle
    if (MECH_DONE_IN) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sel_q <= 1'b0;
      head_q <= '0;
      xs_q <= XS_IDLE;
      req_q <= 1'b0;
      ack_q <= 1'b0;
      cnt_q <= 16'h0;
      sh_q <= '0;
      nbit_q <= 5'h0;
      word_q <= '0;
      stb_q <= 1'b0;
      done_q <= 1'b0;
      attn_q <= 1'b0;
      st_q <= 12'h0;
      motor_q <= 1'b0;
      sofs_q <= OFS_NONE;
      tofs_q <= OFS_NONE;
    end else begin
      sel_q <= sel_d;
      head_q <= head_d;
      xs_q <= xs_d;
      req_q <= req_d;
      ack_q <= ack_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      nbit_q <= nbit_d;
      word_q <= word_d;
      stb_q <= stb_d;
      done_q <= done_d;
      attn_q <= attn_d;
      st_q <= st_d;
      motor_q <= motor_d;
      sofs_q <= sofs_d;
      tofs_q <= tofs_d;
    end
  end

  // Gated cable outputs; head changes never touch ready or done
  assign SELECTED_OUT = sel_q;
  assign READY_OUT = sel_q & MECH_READY_IN & motor_q;
  assign CMD_DONE_OUT = sel_q & done_q;
  assign ATTN_OUT = sel_q & attn_q;
  assign XFER_ACK_OUT = sel_q & ack_q;
  assign HEAD_OUT = head_q;
  assign WRITE_EN_OUT = sel_q & WRITE_GATE_IN;
  assign READ_EN_OUT = sel_q & READ_GATE_IN;
  assign CMD_WORD_OUT = word_q;
  assign CMD_STB_OUT = stb_q;
  assign STATUS_OUT = st_q;
  assign MOTOR_ON_OUT = motor_q;
  assign STROBE_OFS_OUT = sofs_q;
  assign TRACK_OFS_OUT = tofs_q;
endmodule : esdc_drive_ctrl

//--- esdc_host_model.sv
// Purpose: Host controller model that serialises command words
// Assumes: Drive answers each request edge with a matching ack
// Notes: Drives just after the clock edge; err_out flags a stalled handshake
`timescale 1ns/1ps
module esdc_host_model (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic done_in,
  output logic req_out,
  output logic bit_out,
  output logic err_out
);
  initial begin
    req_out = 1'b0;
    bit_out = 1'b0;
    err_out = 1'b0;
  end

  task automatic send(input logic [15:0] w);
    int n;
    n = 0;
    while (done_in !== 1'b1 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 100) err_out = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_in);
      #1;
      bit_out = w[i];
      req_out = ~req_out;
      n = 0;
      while (ack_in !== req_out && n < 100) begin
        @(posedge clk_in);
        n++;
      end
      if (n >= 100) err_out = 1'b1;
    end
    // Released data line shows the inverse, not the last bit
    #1 bit_out = ~bit_out;
  endtask : send
endmodule : esdc_host_model

//--- esdc_drive_ctrl_monitor.sv
// Purpose: Port-level assertions for the drive control block
// Assumes: Single clock domain
// Notes: Attached by bind at the foot of this file
`timescale 1ns/1ps
module esdc_drive_ctrl_monitor
  import esdc_pkg::*;
#(
  parameter int ACK_DELAY = ACK_CYC
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [UNIT_W-1:0] UNIT_ADDR_IN,
  input wire logic [UNIT_W-1:0] DRIVE_SEL_IN,
  input wire logic [HEAD_W-1:0] HEAD_SEL_IN,
  input wire logic XFER_REQ_IN,
  input wire logic MECH_READY_IN,
  input wire logic MECH_DONE_IN,
  input wire logic SELECTED_OUT,
  input wire logic READY_OUT,
  input wire logic CMD_DONE_OUT,
  input wire logic ATTN_OUT,
  input wire logic XFER_ACK_OUT,
  input wire logic [HEAD_W-1:0] HEAD_OUT,
  input wire logic WRITE_EN_OUT,
  input wire logic READ_EN_OUT,
  input wire logic [CMD_W-1:0] CMD_WORD_OUT,
  input wire logic CMD_STB_OUT,
  input wire logic [11:0] STATUS_OUT
);
  localparam int ACK_MAX = ACK_DELAY + 2;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic own;
  logic bad_op;
  assign own = (DRIVE_SEL_IN == UNIT_ADDR_IN) && (UNIT_ADDR_IN != 3'h0);
  assign bad_op = CMD_WORD_OUT[OP_HI:OP_LO] inside {4'h4, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf};
  sequence own_held; own [*8]; endsequence
  sequence other_held; !own [*8]; endsequence
  sequence head_step; $changed(HEAD_SEL_IN) && SELECTED_OUT && !CMD_STB_OUT && !MECH_DONE_IN; endsequence

  a_sel_rise: assert property (own_held |-> SELECTED_OUT) else $error("drive not selected");
  a_sel_fall: assert property (other_held |-> !SELECTED_OUT) else $error("drive not deselected");
  a_idle_quiet: assert property (
    !SELECTED_OUT |-> !(ATTN_OUT | CMD_DONE_OUT | XFER_ACK_OUT | WRITE_EN_OUT | READ_EN_OUT | READY_OUT))
    else $error("output active while idle");
  a_head_follow: assert property (
    (SELECTED_OUT && $stable(HEAD_SEL_IN)) [*3] |-> HEAD_OUT == HEAD_SEL_IN)
    else $error("head number wrong");
  a_head_steady: assert property (
    head_step ##0 $stable(MECH_READY_IN) |=> $stable(READY_OUT) && $stable(CMD_DONE_OUT))
    else $error("ready or done moved on head change");
  a_ack_delay: assert property (
    $changed(XFER_REQ_IN) && SELECTED_OUT && XFER_ACK_OUT != XFER_REQ_IN |-> ##[1:ACK_MAX] XFER_ACK_OUT == XFER_REQ_IN)
    else $error("ack late");
  a_invalid_attn: assert property (
    CMD_STB_OUT && bad_op |-> ##[0:2] ATTN_OUT && STATUS_OUT[ST_INVALID_BIT])
    else $error("invalid opcode not flagged");
  a_clear_attn: assert property (
    CMD_STB_OUT && CMD_WORD_OUT == 16'h5000 |-> ##[0:2] !ATTN_OUT && STATUS_OUT == 12'h000)
    else $error("attention not cleared");
endmodule : esdc_drive_ctrl_monitor

bind esdc_drive_ctrl esdc_drive_ctrl_monitor #(.ACK_DELAY(ACK_DELAY)) u_mon (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .UNIT_ADDR_IN(UNIT_ADDR_IN), .DRIVE_SEL_IN(DRIVE_SEL_IN),
  .HEAD_SEL_IN(HEAD_SEL_IN), .XFER_REQ_IN(XFER_REQ_IN), .MECH_READY_IN(MECH_READY_IN), .MECH_DONE_IN(MECH_DONE_IN),
  .SELECTED_OUT(SELECTED_OUT), .READY_OUT(READY_OUT), .CMD_DONE_OUT(CMD_DONE_OUT), .ATTN_OUT(ATTN_OUT),
  .XFER_ACK_OUT(XFER_ACK_OUT), .HEAD_OUT(HEAD_OUT), .WRITE_EN_OUT(WRITE_EN_OUT), .READ_EN_OUT(READ_EN_OUT),
  .CMD_WORD_OUT(CMD_WORD_OUT), .CMD_STB_OUT(CMD_STB_OUT), .STATUS_OUT(STATUS_OUT));

//--- test_esdi_serial_drive_control.sv
// Purpose: Self-checking bench for the drive control block
// Assumes: Short ack delay parameter of 2 cycles
// Notes: Host model sends command words; bench drives select and head lines
`timescale 1ns/1ps
module test_esdi_serial_drive_control
  import esdc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] unit_addr = 3'h3;
  logic [2:0] drive_sel = 3'h0;
  logic [3:0] head_sel = 4'h0;
  logic rd_gate = 1'b0;
  logic wr_gate = 1'b0;
  logic mech_ready = 1'b1;
  logic mech_done = 1'b0;
  logic xfer_req, cmd_bit, host_err, selected, ready, cmd_done, attn, xfer_ack, wr_en, rd_en, cmd_stb, motor_on;
  logic [3:0] head;
  logic [15:0] cmd_word;
  logic [11:0] status;
  logic [1:0] strobe_ofs, track_ofs;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  always #50 sys_clk = ~sys_clk;

  esdc_drive_ctrl #(.ACK_DELAY(2)) dut (.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .UNIT_ADDR_IN(unit_addr),
    .DRIVE_SEL_IN(drive_sel), .HEAD_SEL_IN(head_sel), .WRITE_GATE_IN(wr_gate), .READ_GATE_IN(rd_gate),
    .XFER_REQ_IN(xfer_req), .CMD_BIT_IN(cmd_bit), .MECH_READY_IN(mech_ready), .MECH_DONE_IN(mech_done),
    .SELECTED_OUT(selected), .READY_OUT(ready), .CMD_DONE_OUT(cmd_done), .ATTN_OUT(attn), .XFER_ACK_OUT(xfer_ack),
    .HEAD_OUT(head), .WRITE_EN_OUT(wr_en), .READ_EN_OUT(rd_en), .CMD_WORD_OUT(cmd_word), .CMD_STB_OUT(cmd_stb),
    .STATUS_OUT(status), .MOTOR_ON_OUT(motor_on), .STROBE_OFS_OUT(strobe_ofs), .TRACK_OFS_OUT(track_ofs));

  esdc_host_model host (.clk_in(sys_clk), .ack_in(xfer_ack), .done_in(cmd_done), .req_out(xfer_req),
    .bit_out(cmd_bit), .err_out(host_err));

  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic sel_scan;
    for (int u = 0; u < 8; u++) begin
      drive_sel = 3'(u);
      tick(10);
      check(16'(selected), 16'(u == 3));
      check(16'({ready, attn, cmd_done}), 16'h0);
    end
    drive_sel = 3'h3;
    tick(10);
  endtask : sel_scan

  task automatic cmd_cases;
    logic [3:0] bad [6] = '{4'h4, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf};
    logic [3:0] good [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'he};
    host.send(16'h5300);
    tick(3);
    check(16'({motor_on, ready}), 16'h3);
    foreach (good[i]) begin
      host.send({good[i], 12'h000});
      tick(3);
      check(cmd_word, {good[i], 12'h000});
      check(16'({attn, status}), 16'h0);
    end
    foreach (bad[i]) begin
      host.send({bad[i], 12'h000});
      tick(3);
      check(cmd_word, {bad[i], 12'h000});
      check(16'({attn, status[ST_INVALID_BIT]}), 16'h3);
      host.send(16'h5000);
      tick(3);
      check(16'({attn, status}), 16'h0);
    end
    // Control with an unlisted modifier
    host.send(16'h5100);
    tick(3);
    check(16'({attn, status[ST_INVALID_BIT]}), 16'h3);
    host.send(16'h5000);
    tick(3);
    check(16'({attn, status}), 16'h0);
  endtask : cmd_cases

  task automatic head_scan;
    rd_gate = 1'b1;
    for (int h = 0; h < 16; h++) begin
      head_sel = 4'(h);
      tick(3);
      check(16'(head), 16'(h));
      check(16'({ready, cmd_done, rd_en}), 16'h7);
    end
  endtask : head_scan

  task automatic write_case;
    head_sel = 4'h5;
    tick(50);
    wr_gate = 1'b1;
    tick(2);
    check(16'(wr_en), 16'h1);
    wr_gate = 1'b0;
    tick(10);
    check(16'(wr_en), 16'h0);
    drive_sel = 3'h2;
    wr_gate = 1'b1;
    tick(10);
    check(16'({selected, wr_en, rd_en}), 16'h0);
    wr_gate = 1'b0;
    drive_sel = 3'h3;
    tick(10);
    check(16'({selected, ready, cmd_done}), 16'h7);
  endtask : write_case

  task automatic ofs_cases;
    for (int m = 0; m < 4; m++) begin
      host.send({4'h6, 2'h0, 2'(m), 8'h00});
      tick(3);
      check(16'(strobe_ofs), 16'((m == 0) ? OFS_NONE : STROBE_SINGLE));
      host.send({4'h7, 2'h0, 2'(m), 8'h00});
      tick(3);
      check(16'(track_ofs), 16'(m));
    end
  endtask : ofs_cases

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    tick(12);
    rst_n = 1'b1;
    // Power-up wait before first select, scaled down
    tick(3);
    sel_scan();
    mech_done = 1'b1;
    tick(1);
    mech_done = 1'b0;
    cmd_cases();
    head_scan();
    write_case();
    ofs_cases();
    check(16'(host_err), 16'h0);
    test_done();
  end
endmodule : test_esdi_serial_drive_control
